// ==== rtl/pvs_pkg.sv ====
// Purpose: Shared constants and types for the peak/valley symbol slicer
// Assumes: 8-bit peak and valley counters, comparator results arrive as pins
// Notes:   Mode encoding on the tracking-mode input is internal to this block
package pvs_pkg;
    localparam int          PVS_CNT_W        = 8;
    localparam int          PVS_DECAY_IDLE   = 16;
    localparam logic [7:0]  PVS_PEAK_RST     = 8'h80;
    localparam logic [7:0]  PVS_VALLEY_RST   = 8'h80;
    localparam logic [7:0]  PVS_CNT_MAX      = 8'hFF;
    localparam logic [7:0]  PVS_CNT_MIN      = 8'h00;
    localparam int          PVS_SIXTHS       = 6;
    localparam int          PVS_UPPER_NUM    = 5;
    localparam int          PVS_MID_NUM      = 3;
    localparam int          PVS_LOWER_NUM    = 1;
    localparam logic [1:0]  PVS_SYM_TOP      = 2'h2;
    localparam logic [1:0]  PVS_SYM_UPMID    = 2'h3;
    localparam logic [1:0]  PVS_SYM_LOWMID   = 2'h1;
    localparam logic [1:0]  PVS_SYM_BOTTOM   = 2'h0;
    localparam logic [1:0]  PVS_MODE_FAST    = 2'h0;
    localparam logic [1:0]  PVS_MODE_SLOW    = 2'h1;
    localparam logic [1:0]  PVS_MODE_HOLD    = 2'h2;
    localparam real         PVS_CLK_MHZ      = 50.0;
    localparam real         PVS_SYMBOL_US    = 625.0;
    localparam int          PVS_SYMBOL_CYC   = int'(PVS_SYMBOL_US * PVS_CLK_MHZ);
    typedef enum logic [1:0] {PVS_FAST, PVS_SLOW, PVS_HOLD} pvs_mode_t;
endpackage

// ==== rtl/pvs_slicer.sv ====
// Purpose: Digital control of a four-level symbol slicer with peak/valley servo loops
// Assumes: Comparator results and the tracking clock are pins from outside, synchronised here
// Notes:   Threshold slicing uses the digital codes, matching the analog comparison ideally
// Behaviour
// - Compare input against valley-based thresholds at five sixths, half, one sixth of span.
// - Output Gray symbol: 10 top, 11 upper-middle, 01 lower-middle, 00 bottom.
// - Peak and valley each held in 8-bit counter driving its own DAC.
// - Acquisition completes within six 1600 symbol/s periods, thresholds within 5%.
// - Fast mode: peak decays when DAC above input, attacks when below, ignoring inhibit.
// - Slow mode: peak decays only uninhibited, DAC above input, after idle cycles.
// - Slow mode: peak attacks whenever uninhibited and DAC below input.
// - Valley counter follows same rules with comparisons reversed.
`timescale 1ns/1ns
module pvs_slicer
    import pvs_pkg::*;
#(
    parameter int DECAY_IDLE = PVS_DECAY_IDLE
) (
    input  wire logic                 CLK,
    input  wire logic                 RESET,
    input  wire logic                 TRACK_CLOCK,
    input  wire logic [1:0]           TRACK_MODE,
    input  wire logic                 TRACKING_INHIBIT,
    input  wire logic [PVS_CNT_W-1:0] ANALOG_SYMBOL_INPUT,
    input  wire logic                 PEAK_DAC_ABOVE,
    input  wire logic                 VALLEY_DAC_BELOW,
    output logic [PVS_CNT_W-1:0]      PEAK_DAC,
    output logic [PVS_CNT_W-1:0]      VALLEY_DAC,
    output logic                      SYMBOL_BIT_HIGH,
    output logic                      SYMBOL_BIT_LOW
);
    localparam int IW = $clog2(DECAY_IDLE + 1);
    localparam int SW = PVS_CNT_W + 4;

    logic                 tclk;
    logic [1:0]           mode_w;
    logic                 inhibit;
    logic [PVS_CNT_W-1:0] vin;
    logic                 pk_above;
    logic                 vl_below;
    logic                 tclk_d_r;
    logic [PVS_CNT_W-1:0] peak_r;
    logic [PVS_CNT_W-1:0] peak_nxt;
    logic [PVS_CNT_W-1:0] valley_r;
    logic [PVS_CNT_W-1:0] valley_nxt;
    logic [IW-1:0]        pidle_r;
    logic [IW-1:0]        pidle_nxt;
    logic [IW-1:0]        vidle_r;
    logic [IW-1:0]        vidle_nxt;
    logic [1:0]           sym_nxt;

    // Each pin crosses in its own two-flop stage
    pvs_sync #(.W(1)) tclk_sync (
        .clk  (CLK),
        .rst  (RESET),
        .din  (TRACK_CLOCK),
        .dout (tclk)
    );
    // Mode going 1 to 2 may show 0 or 3 for a cycle; change it between steps
    pvs_sync #(.W(2)) mode_sync (
        .clk  (CLK),
        .rst  (RESET),
        .din  (TRACK_MODE),
        .dout (mode_w)
    );
    pvs_sync #(.W(1)) inhibit_sync (
        .clk  (CLK),
        .rst  (RESET),
        .din  (TRACKING_INHIBIT),
        .dout (inhibit)
    );
    // Level word may skew by a code for one cycle; slicing only, no state
    pvs_sync #(.W(PVS_CNT_W)) level_sync (
        .clk  (CLK),
        .rst  (RESET),
        .din  (ANALOG_SYMBOL_INPUT),
        .dout (vin)
    );
    pvs_sync #(.W(1)) peak_cmp_sync (
        .clk  (CLK),
        .rst  (RESET),
        .din  (PEAK_DAC_ABOVE),
        .dout (pk_above)
    );
    pvs_sync #(.W(1)) valley_cmp_sync (
        .clk  (CLK),
        .rst  (RESET),
        .din  (VALLEY_DAC_BELOW),
        .dout (vl_below)
    );

    // One servo step per tracking-clock rise sets the acquisition pace
    wire                 tick       = tclk & ~tclk_d_r;
    wire                 fast       = (mode_w == PVS_MODE_FAST);
    wire                 slow       = (mode_w == PVS_MODE_SLOW);
    wire                 pidle_done = (pidle_r >= IW'(DECAY_IDLE));
    wire                 vidle_done = (vidle_r >= IW'(DECAY_IDLE));
    wire                 pk_min     = (peak_r == PVS_CNT_MIN);
    wire                 pk_max     = (peak_r == PVS_CNT_MAX);
    wire                 vl_min     = (valley_r == PVS_CNT_MIN);
    wire                 vl_max     = (valley_r == PVS_CNT_MAX);

    // Peak servo: attack up, decay down
    wire p_dec = tick & ~pk_min & pk_above &
                 (fast | (slow & ~inhibit & pidle_done));
    wire p_inc = tick & ~pk_max & ~pk_above & (fast | (slow & ~inhibit));
    // Valley servo mirrored: attack down, decay up
    wire v_inc = tick & ~vl_max & vl_below &
                 (fast | (slow & ~inhibit & vidle_done));
    wire v_dec = tick & ~vl_min & ~vl_below & (fast | (slow & ~inhibit));

    // Hold mode leaves neither fast nor slow true, so peak and valley counters freeze
    assign peak_nxt   = p_inc ? peak_r + 1'b1 : (p_dec ? peak_r - 1'b1 : peak_r);
    assign valley_nxt = v_inc ? valley_r + 1'b1 : (v_dec ? valley_r - 1'b1 : valley_r);
    assign pidle_nxt  = (p_inc | p_dec) ? '0 : ((tick & ~pidle_done) ? pidle_r + 1'b1 : pidle_r);
    assign vidle_nxt  = (v_inc | v_dec) ? '0 : ((tick & ~vidle_done) ? vidle_r + 1'b1 : vidle_r);

    // Thresholds scaled by six to stay in integers
    wire [SW-1:0] span  = SW'(peak_r) - SW'(valley_r);
    wire [SW-1:0] vin6  = SW'(vin) * SW'(PVS_SIXTHS);
    wire [SW-1:0] vl6   = SW'(valley_r) * SW'(PVS_SIXTHS);
    wire [SW-1:0] th_up = vl6 + span * SW'(PVS_UPPER_NUM);
    wire [SW-1:0] th_md = vl6 + span * SW'(PVS_MID_NUM);
    wire [SW-1:0] th_lo = vl6 + span * SW'(PVS_LOWER_NUM);
    assign sym_nxt = (vin6 > th_up) ? PVS_SYM_TOP :
                     (vin6 > th_md) ? PVS_SYM_UPMID :
                     (vin6 > th_lo) ? PVS_SYM_LOWMID : PVS_SYM_BOTTOM;

    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            tclk_d_r        <= 1'b0;
            peak_r          <= PVS_PEAK_RST;
            valley_r        <= PVS_VALLEY_RST;
            pidle_r         <= '0;
            vidle_r         <= '0;
            SYMBOL_BIT_HIGH <= 1'b0;
            SYMBOL_BIT_LOW  <= 1'b0;
        end else begin
            tclk_d_r        <= tclk;
            peak_r          <= peak_nxt;
            valley_r        <= valley_nxt;
            pidle_r         <= pidle_nxt;
            vidle_r         <= vidle_nxt;
            SYMBOL_BIT_HIGH <= sym_nxt[1];
            SYMBOL_BIT_LOW  <= sym_nxt[0];
        end
    end

    assign PEAK_DAC   = peak_r;
    assign VALLEY_DAC = valley_r;

    peak_step_a: assert property (@(posedge CLK) disable iff (RESET)
        (peak_r != $past(peak_r)) |-> $past(tick)) else $error("peak moved without a tick");
    hold_freeze_a: assert property (@(posedge CLK) disable iff (RESET)
        $past(mode_w) == PVS_MODE_HOLD |-> $stable(peak_r) && $stable(valley_r))
        else $error("counter moved in hold");
    fast_decay_a: assert property (@(posedge CLK) disable iff (RESET)
        (tick && fast && pk_above && !pk_min) |=> peak_r == $past(peak_r) - 1'b1)
        else $error("fast peak decay missing");
    slow_attack_a: assert property (@(posedge CLK) disable iff (RESET)
        (tick && slow && !inhibit && !pk_above && !pk_max) |=> peak_r == $past(peak_r) + 1'b1)
        else $error("slow peak attack missing");
    slow_idle_a: assert property (@(posedge CLK) disable iff (RESET)
        (slow && !pidle_done) |=> peak_r >= $past(peak_r)) else $error("slow decay too early");
    inhibit_a: assert property (@(posedge CLK) disable iff (RESET)
        (slow && inhibit) |=> $stable(peak_r)) else $error("inhibit ignored");
    valley_fast_a: assert property (@(posedge CLK) disable iff (RESET)
        (tick && fast && !vl_below && !vl_min) |=> valley_r == $past(valley_r) - 1'b1)
        else $error("valley attack missing");
    symbol_top_a: assert property (@(posedge CLK) disable iff (RESET)
        (vin6 > th_up) |=> {SYMBOL_BIT_HIGH, SYMBOL_BIT_LOW} == PVS_SYM_TOP)
        else $error("top symbol wrong");
    symbol_bottom_a: assert property (@(posedge CLK) disable iff (RESET)
        (vin6 <= th_lo) |=> {SYMBOL_BIT_HIGH, SYMBOL_BIT_LOW} == PVS_SYM_BOTTOM)
        else $error("bottom symbol wrong");
    fast_attack_a: assert property (@(posedge CLK) disable iff (RESET)
        (tick && fast && !pk_above && !pk_max) |=> peak_r == $past(peak_r) + 1'b1)
        else $error("fast peak attack missing");
    slow_decay_a: assert property (@(posedge CLK) disable iff (RESET)
        (tick && slow && !inhibit && pk_above && pidle_done && !pk_min) |=> peak_r == $past(peak_r) - 1'b1)
        else $error("slow peak decay missing");
    valley_slow_a: assert property (@(posedge CLK) disable iff (RESET)
        (tick && slow && !inhibit && !vl_below && !vl_min) |=> valley_r == $past(valley_r) - 1'b1)
        else $error("slow valley attack missing");
    valley_decay_a: assert property (@(posedge CLK) disable iff (RESET)
        (tick && slow && !inhibit && vl_below && vidle_done && !vl_max) |=> valley_r == $past(valley_r) + 1'b1)
        else $error("slow valley decay missing");
    idle_restart_a: assert property (@(posedge CLK) disable iff (RESET)
        (p_inc || p_dec) |=> pidle_r == '0)
        else $error("idle count not restarted");
    symbol_upmid_a: assert property (@(posedge CLK) disable iff (RESET)
        (vin6 > th_md && vin6 <= th_up) |=> {SYMBOL_BIT_HIGH, SYMBOL_BIT_LOW} == PVS_SYM_UPMID)
        else $error("upper middle symbol wrong");
    symbol_lowmid_a: assert property (@(posedge CLK) disable iff (RESET)
        (vin6 > th_lo && vin6 <= th_md) |=> {SYMBOL_BIT_HIGH, SYMBOL_BIT_LOW} == PVS_SYM_LOWMID)
        else $error("lower middle symbol wrong");
endmodule // pvs_slicer

// Two-flop synchroniser; only the second stage is read outside
module pvs_sync
    import pvs_pkg::*;
#(
    parameter int W = 1
) (
    input  wire logic         clk,
    input  wire logic         rst,
    input  wire logic [W-1:0] din,
    output logic [W-1:0]      dout
);
    logic [W-1:0] meta_r;
    logic [W-1:0] sync_r;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            meta_r <= '0;
            sync_r <= '0;
        end else begin
            meta_r <= din;
            sync_r <= meta_r;
        end
    end

    assign dout = sync_r;
endmodule // pvs_sync

// ==== tb/pvs_decoder_model.sv ====
// Purpose: Decoder-side model: free-running tracking clock and ideal comparators
// Assumes: DAC codes and input level share one 8-bit scale
// Notes:   HALF shortens the 38.4 kHz half period for short runs
`timescale 1ns/1ns
module pvs_decoder_model
    import pvs_pkg::*;
#(
    parameter int HALF = 651
) (
    input  wire logic                 clk,
    input  wire logic [PVS_CNT_W-1:0] level,
    input  wire logic [PVS_CNT_W-1:0] peak_dac,
    input  wire logic [PVS_CNT_W-1:0] valley_dac,
    output logic                      track_clock,
    output logic                      peak_above,
    output logic                      valley_below
);
    int unsigned half_cnt_r = 0;
    logic        tclk_r     = 1'b0;
    // Runs free, never gated between steps
    always @(posedge clk) begin
        half_cnt_r <= (half_cnt_r == HALF - 1) ? 0 : half_cnt_r + 1;
        if (half_cnt_r == HALF - 1)
            tclk_r <= ~tclk_r;
    end
    assign track_clock = tclk_r;
    assign peak_above   = peak_dac > level;
    assign valley_below = valley_dac < level;
endmodule // pvs_decoder_model

// ==== tb/pvs_slicer_test.sv ====
// Purpose: Self-checking bench for the peak/valley symbol slicer
// Assumes: Fixed step length from the decoder model, no open waits
// Notes:   Idle count shortened to 2 steps
`timescale 1ns/1ns
module pvs_slicer_test import pvs_pkg::*; ;
    localparam int HALF = 8;
    localparam int IDLE = 2;
    logic       clk, reset, trk_clk, inhibit, peak_above, valley_below, sym_hi, sym_lo;
    logic [1:0] mode;
    logic [7:0] level, peak, valley;
    int         bad_count = 0;
    int         n_tests = 0;
    pvs_slicer #(.DECAY_IDLE(IDLE)) dut (.CLK(clk), .RESET(reset), .TRACK_CLOCK(trk_clk),
        .TRACK_MODE(mode), .TRACKING_INHIBIT(inhibit), .ANALOG_SYMBOL_INPUT(level),
        .PEAK_DAC_ABOVE(peak_above), .VALLEY_DAC_BELOW(valley_below), .PEAK_DAC(peak),
        .VALLEY_DAC(valley), .SYMBOL_BIT_HIGH(sym_hi), .SYMBOL_BIT_LOW(sym_lo));
    pvs_decoder_model #(.HALF(HALF)) partner (.clk(clk), .level(level), .peak_dac(peak),
        .valley_dac(valley), .track_clock(trk_clk), .peak_above(peak_above), .valley_below(valley_below));
    task automatic check(string what, logic [7:0] seen, logic [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            bad_count++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic near(string what, logic [7:0] seen, logic [7:0] tgt);
        check(what, {7'h00, (seen + 8'h01 >= tgt) && (seen <= tgt + 8'h01)}, 8'h01);
    endtask
    task automatic steps(int n);
        repeat (n * 2 * HALF + 6) @(posedge clk);
    endtask
    function automatic logic [7:0] exp_sym(int x, int p, int v);
        if (6 * x > 6 * v + 5 * (p - v)) return 8'h02;
        if (2 * x > 2 * v + (p - v)) return 8'h03;
        if (6 * x > 6 * v + (p - v)) return 8'h01;
        return 8'h00;
    endfunction
    task automatic acquire();
        logic [7:0] p, v;
        // Fast only for one symbol period, 24 steps
        mode <= PVS_MODE_FAST;
        level <= 8'h70;
        steps(24);
        near("fast peak", peak, 8'h70);
        near("fast valley", valley, 8'h70);
        mode <= PVS_MODE_SLOW;
        steps(1);
        p = peak;
        v = valley;
        level <= 8'hF0;
        steps(10);
        check("inhibited peak", peak, p);
        check("inhibited valley", valley, v);
        inhibit <= 1'b0;
        steps(184);
        near("attack peak", peak, 8'hF0);
        p = peak;
        level <= 8'h10;
        steps(12);
        // Fast-rate decay would drop 12 here
        check("slow decay", {7'h00, (p > peak) && (p - peak <= 8'h07)}, 8'h01);
        steps(176);
        near("attack valley", valley, 8'h10);
        $display("acquire done");
    endtask
    task automatic slice_hold();
        logic [7:0] p, v;
        int         x;
        mode <= PVS_MODE_HOLD;
        steps(1);
        p = peak;
        v = valley;
        for (x = 0; x < 256; x += 16) begin
            level <= x[7:0];
            repeat (6) @(posedge clk);
            check("symbol", {6'h00, sym_hi, sym_lo}, exp_sym(x, p, v));
        end
        check("hold peak", peak, p);
        check("hold valley", valley, v);
        $display("slice_hold done");
    endtask
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    initial begin
        reset = 1'b1;
        mode = PVS_MODE_HOLD;
        inhibit = 1'b1;
        level = 8'h80;
        repeat (20) @(posedge clk);
        reset <= 1'b0;
        acquire();
        slice_hold();
        give_verdict();
    end
endmodule // pvs_slicer_test
